// file: event_interrupt_aggregator.v
// Event interrupt aggregator: edge-detected pending latches, APB registers, open-drain request.
//
// Overview of operation
// - The request pin is open drain and active low: it is only pulled low or released.
// - An enabled event sets its pending latch on a rising edge; a disabled event holds it at zero.
// - The request pin is pulled low while any pending latch of any block is set.
// - A pending latch clears on its clear write or on device reset.
// - Each status readback bit returns either the live event or the pending latch.
// - The logic monitors up to 75 events, here 73 spread over four blocks.
// - Per-chip readback shows the latch when enabled and the live event when disabled.
// - Per-link and per-lane readback shows the latch when enabled and zero when disabled.
// - Per-chip enables sit in four read/write registers, one bit per event.
// - Writing a per-chip status bit clears that latch; reading returns the readback.
// - Lane-group enables are per link in the shared register, clears are per lane in three.
// - Link-group clears are per link in four registers, enable and readback are shared.
// - The single per-link event has enable at bit 3 resetting to 1, clear and status at bit 4.
// - Test-pattern failure events use the low four bits of the second per-chip registers.
`include "event_irq_regs.vh"

module event_interrupt_aggregator #(
  parameter CHIP_EVENTS = 32,
  parameter LINKS = 8,
  parameter LANE_TYPES = 3,
  parameter LINK_TYPES = 2
) (
  input wire clk,
  input wire rst,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [13:0] paddr,
  input wire [31:0] pwdata,
  output wire [31:0] prdata,
  output wire pready,
  output wire pslverr,
  input wire [CHIP_EVENTS-1:0] chip_event,
  input wire [LINKS*LANE_TYPES-1:0] lane_event,
  input wire [LINKS*LINK_TYPES-1:0] link_event,
  input wire single_event,
  output wire irq_n_o,
  output wire irq_n_oe,
  output wire irq_level
);

  localparam LANE_EVENTS = LINKS * LANE_TYPES;
  localparam LINK_EVENTS = LINKS * LINK_TYPES;

  // --------------------------------------------------------------------------
  // Register state
  // --------------------------------------------------------------------------
  reg [CHIP_EVENTS-1:0] chip_en_ff;
  reg [LINKS-1:0] link_en_ff;
  reg single_en_ff;
  reg [2:0] sum_en_ff;
  reg [2:0] sum_st_ff;
  wire [CHIP_EVENTS-1:0] chip_pend;
  wire [LANE_EVENTS-1:0] lane_pend;
  wire [LINK_EVENTS-1:0] link_pend;
  wire single_pend;
  wire [CHIP_EVENTS-1:0] chip_new;
  wire [LANE_EVENTS-1:0] lane_new;
  wire [LINK_EVENTS-1:0] link_new;
  wire single_new;
  reg pready_ff;
  reg pslverr_ff;
  reg [31:0] prdata_ff;
  reg irq_n_oe_ff;
  reg irq_n_o_ff;
  reg irq_level_ff;

  // --------------------------------------------------------------------------
  // APB decode
  // --------------------------------------------------------------------------
  // The slave answers one cycle into the access phase, so every transfer is
  // setup plus two access cycles; read data is registered in the first.
  wire [11:0] idx = paddr[13:2];
  wire access = psel & penable & ~pready_ff;
  wire commit = psel & penable & pready_ff;
  wire wr = commit & pwrite;
  wire [1:0] chip_en_off;
  wire [1:0] chip_st_off;
  wire [1:0] lane_off;
  wire [1:0] link_off;
  wire hit_chip_en;
  wire hit_chip_st;
  wire hit_lane_clr;
  wire hit_link_clr;
  reg_window #(
    .FIRST(`IDX_CHIP_EN_FIRST),
    .LAST(`IDX_CHIP_EN_LAST)
  ) u_chip_en_win (
    .idx(idx),
    .hit(hit_chip_en),
    .offset(chip_en_off)
  );
  reg_window #(
    .FIRST(`IDX_CHIP_ST_FIRST),
    .LAST(`IDX_CHIP_ST_LAST)
  ) u_chip_st_win (
    .idx(idx),
    .hit(hit_chip_st),
    .offset(chip_st_off)
  );
  reg_window #(
    .FIRST(`IDX_LANE_CLR_FIRST),
    .LAST(`IDX_LANE_CLR_LAST)
  ) u_lane_clr_win (
    .idx(idx),
    .hit(hit_lane_clr),
    .offset(lane_off)
  );
  reg_window #(
    .FIRST(`IDX_LINK_CLR_FIRST),
    .LAST(`IDX_LINK_CLR_LAST)
  ) u_link_clr_win (
    .idx(idx),
    .hit(hit_link_clr),
    .offset(link_off)
  );
  wire hit_link_en = (idx == `IDX_LINK_EN_ST);
  wire hit_single = (idx == `IDX_SINGLE_CTRL);
  wire hit_sum_st = (idx == `IDX_SUM_STATUS);
  wire hit_sum_clr = (idx == `IDX_SUM_CLEAR);
  wire hit_sum_en = (idx == `IDX_SUM_ENABLE);
  wire mapped = hit_chip_en | hit_chip_st | hit_lane_clr | hit_link_clr | hit_link_en |
                hit_single | hit_sum_st | hit_sum_clr | hit_sum_en;

  // --------------------------------------------------------------------------
  // Clear pulses and enable fan-out
  // --------------------------------------------------------------------------
  reg [CHIP_EVENTS-1:0] chip_clr;
  reg [LANE_EVENTS-1:0] lane_clr;
  reg [LINK_EVENTS-1:0] link_clr;
  reg [LANE_EVENTS-1:0] lane_en;
  reg [LINK_EVENTS-1:0] link_en;
  reg [LINKS-1:0] link_rb;
  integer i;

  always @* begin
    chip_clr = {CHIP_EVENTS{1'b0}};
    lane_clr = {LANE_EVENTS{1'b0}};
    link_clr = {LINK_EVENTS{1'b0}};
    lane_en = {LANE_EVENTS{1'b0}};
    link_en = {LINK_EVENTS{1'b0}};
    link_rb = {LINKS{1'b0}};
    for (i = 0; i < CHIP_EVENTS; i = i + 1) begin
      if (wr && hit_chip_st && (chip_st_off[1:0] == i / 8)) begin
        chip_clr[i] = pwdata[i % 8];
      end
    end
    // Lane-group register k holds event type k, one bit per link.
    for (i = 0; i < LANE_EVENTS; i = i + 1) begin
      lane_en[i] = link_en_ff[i % LINKS];
      if (wr && hit_lane_clr && (lane_off[1:0] == i / LINKS)) begin
        lane_clr[i] = pwdata[i % LINKS];
      end
      link_rb[i % LINKS] = link_rb[i % LINKS] | lane_pend[i];
    end
    // Link-group register k holds two links of two event types each.
    for (i = 0; i < LINK_EVENTS; i = i + 1) begin
      link_en[i] = link_en_ff[i / LINK_TYPES];
      if (wr && hit_link_clr && (link_off[1:0] == i / `LINK_CLR_USED_BITS)) begin
        link_clr[i] = pwdata[i % `LINK_CLR_USED_BITS];
      end
      link_rb[i / LINK_TYPES] = link_rb[i / LINK_TYPES] | link_pend[i];
    end
  end

  // --------------------------------------------------------------------------
  // Pending latches
  // --------------------------------------------------------------------------
  wire single_clr = wr & hit_single & pwdata[`SINGLE_ST_BIT];
  // Test-pattern fail events enter on chip_event[11:8], the low nibble of the second register.
  event_latch_bank #(
    .WIDTH(CHIP_EVENTS)
  ) u_chip_latch (
    .clk(clk),
    .rst(rst),
    .event_level(chip_event),
    .enable(chip_en_ff),
    .clear(chip_clr),
    .pending(chip_pend),
    .newly_set(chip_new)
  );

  event_latch_bank #(
    .WIDTH(LANE_EVENTS)
  ) u_lane_latch (
    .clk(clk),
    .rst(rst),
    .event_level(lane_event),
    .enable(lane_en),
    .clear(lane_clr),
    .pending(lane_pend),
    .newly_set(lane_new)
  );

  event_latch_bank #(
    .WIDTH(LINK_EVENTS)
  ) u_link_latch (
    .clk(clk),
    .rst(rst),
    .event_level(link_event),
    .enable(link_en),
    .clear(link_clr),
    .pending(link_pend),
    .newly_set(link_new)
  );

  event_latch_bank #(
    .WIDTH(1)
  ) u_single_latch (
    .clk(clk),
    .rst(rst),
    .event_level(single_event),
    .enable(single_en_ff),
    .clear(single_clr),
    .pending(single_pend),
    .newly_set(single_new)
  );

  wire any_pend = (|chip_pend) | (|lane_pend) | (|link_pend) | single_pend;

  // Per-chip readback follows the enable; latches are already zero when disabled.
  wire [CHIP_EVENTS-1:0] chip_rb =
    (chip_en_ff & chip_pend) | (~chip_en_ff & chip_event);
  wire single_rb = single_pend;

  // --------------------------------------------------------------------------
  // Group summary events
  // --------------------------------------------------------------------------
  wire [2:0] sum_set;
  assign sum_set[`SUM_CHIP_BIT] = |chip_new;
  assign sum_set[`SUM_LINK_BIT] = (|lane_new) | (|link_new);
  assign sum_set[`SUM_SINGLE_BIT] = single_new;
  wire [2:0] sum_clr = (wr && hit_sum_clr) ? pwdata[2:0] : 3'h0;
  wire [2:0] nxt_sum_st = (sum_st_ff & ~sum_clr) | sum_set;

  // --------------------------------------------------------------------------
  // Read mux
  // --------------------------------------------------------------------------
  reg [31:0] nxt_rdata;

  always @* begin
    nxt_rdata = 32'h00000000;
    if (hit_chip_en) begin
      nxt_rdata[7:0] = chip_en_ff[chip_en_off[1:0]*8 +: 8];
    end else if (hit_chip_st) begin
      nxt_rdata[7:0] = chip_rb[chip_st_off[1:0]*8 +: 8];
    end else if (hit_link_en) begin
      nxt_rdata[LINKS-1:0] = link_rb;
    end else if (hit_single) begin
      nxt_rdata[`SINGLE_EN_BIT] = single_en_ff;
      nxt_rdata[`SINGLE_ST_BIT] = single_rb;
    end else if (hit_sum_st) begin
      nxt_rdata[2:0] = sum_st_ff;
    end else if (hit_sum_en) begin
      nxt_rdata[2:0] = sum_en_ff;
    end
  end

  // --------------------------------------------------------------------------
  // Sequential logic
  // --------------------------------------------------------------------------
  always @(posedge clk) begin
    if (rst) begin
      chip_en_ff <= `CHIP_EN_RST;
      link_en_ff <= `LINK_EN_RST;
      single_en_ff <= `SINGLE_EN_RST;
      sum_en_ff <= `SUM_EN_RST;
      sum_st_ff <= `SUM_ST_RST;
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= 32'h00000000;
      irq_n_oe_ff <= 1'b0;
      irq_n_o_ff <= `IRQ_PIN_LOW;
      irq_level_ff <= 1'b0;
    end else begin
      if (wr && hit_chip_en) begin
        chip_en_ff[chip_en_off[1:0]*8 +: 8] <= pwdata[7:0];
      end
      if (wr && hit_link_en) begin
        link_en_ff <= pwdata[LINKS-1:0];
      end
      if (wr && hit_single) begin
        single_en_ff <= pwdata[`SINGLE_EN_BIT];
      end
      if (wr && hit_sum_en) begin
        sum_en_ff <= pwdata[2:0];
      end
      sum_st_ff <= nxt_sum_st;
      pready_ff <= access;
      if (access) begin
        pslverr_ff <= ~mapped;
        prdata_ff <= pwrite ? 32'h00000000 : nxt_rdata;
      end else begin
        pslverr_ff <= 1'b0;
      end
      // The pin is never driven high; the enable alone pulls it low.
      irq_n_o_ff <= `IRQ_PIN_LOW;
      irq_n_oe_ff <= any_pend;
      irq_level_ff <= |(sum_st_ff & sum_en_ff);
    end
  end

  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign irq_n_o = irq_n_o_ff;
  assign irq_n_oe = irq_n_oe_ff;
  assign irq_level = irq_level_ff;

endmodule // event_interrupt_aggregator

// ----------------------------------------------------------------------------
// Edge-detected pending latches of one event group
// ----------------------------------------------------------------------------
module event_latch_bank #(
  parameter WIDTH = 1
) (
  input wire clk,
  input wire rst,
  input wire [WIDTH-1:0] event_level,
  input wire [WIDTH-1:0] enable,
  input wire [WIDTH-1:0] clear,
  output wire [WIDTH-1:0] pending,
  output wire [WIDTH-1:0] newly_set
);

  reg [WIDTH-1:0] prev_ff;
  reg [WIDTH-1:0] pend_ff;

  // A rising edge in the cycle of its clear write still sets the latch, so an
  // event is never lost to a clear that raced it.
  wire [WIDTH-1:0] rise = event_level & ~prev_ff;
  wire [WIDTH-1:0] nxt_pend = enable & ((pend_ff & ~clear) | rise);

  always @(posedge clk) begin
    if (rst) begin
      // Loading the live level means a level already high at reset is no edge.
      prev_ff <= event_level;
      pend_ff <= {WIDTH{1'b0}};
    end else begin
      prev_ff <= event_level;
      pend_ff <= nxt_pend;
    end
  end

  assign pending = pend_ff;
  assign newly_set = nxt_pend & ~pend_ff;

endmodule // event_latch_bank

// ----------------------------------------------------------------------------
// Register index window decode
// ----------------------------------------------------------------------------
module reg_window #(
  parameter FIRST = 12'h000,
  parameter LAST = 12'h000
) (
  input wire [11:0] idx,
  output wire hit,
  output wire [1:0] offset
);

  wire [11:0] distance = idx - FIRST;

  assign hit = (idx >= FIRST) && (idx <= LAST);
  // No window spans more than four registers, so two bits name the member.
  assign offset = distance[1:0];

endmodule // reg_window

// file: event_irq_regs.vh
// Register indexes, field positions and reset values of the event interrupt aggregator.
`ifndef EVENT_IRQ_REGS_VH
`define EVENT_IRQ_REGS_VH

// ----------------------------------------------------------------------------
// Register indexes (byte address is four times the index)
// ----------------------------------------------------------------------------
`define IDX_CHIP_EN_FIRST 12'h01f
`define IDX_CHIP_EN_LAST 12'h022
`define IDX_CHIP_ST_FIRST 12'h023
`define IDX_CHIP_ST_LAST 12'h026
`define IDX_LANE_CLR_FIRST 12'h46d
`define IDX_LANE_CLR_LAST 12'h46f
`define IDX_LINK_CLR_FIRST 12'h470
`define IDX_LINK_CLR_LAST 12'h473
`define IDX_LINK_EN_ST 12'h47a
`define IDX_SINGLE_CTRL 12'h47b
`define IDX_SUM_STATUS 12'h480
`define IDX_SUM_CLEAR 12'h481
`define IDX_SUM_ENABLE 12'h482

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define SINGLE_EN_BIT 3
`define SINGLE_ST_BIT 4
`define SUM_CHIP_BIT 0
`define SUM_LINK_BIT 1
`define SUM_SINGLE_BIT 2
`define LINK_CLR_USED_BITS 4

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define CHIP_EN_RST 32'h00000000
`define LINK_EN_RST 8'h00
`define SINGLE_EN_RST 1'b1
`define SUM_EN_RST 3'h0
`define SUM_ST_RST 3'h0
`define IRQ_PIN_LOW 1'b0

`endif

// file: irq_host_line.sv
// Host side of the open-drain request line: pull-up resistor and wired level.
module irq_host_line (
  input wire logic irq_n_o,
  input wire logic irq_n_oe,
  output logic irq_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  // The pull-up owns the line whenever the device lets go of it.
  assign irq_pin = irq_n_oe ? irq_n_o : 1'b1;
endmodule // irq_host_line

// file: irq_monitor.sv
// Checker of the event interrupt aggregator ports.
module irq_monitor #(
  parameter CHIP_EVENTS = 32,
  parameter LINKS = 8,
  parameter LANE_TYPES = 3,
  parameter LINK_TYPES = 2
) (
  input wire clk,
  input wire rst,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [13:0] paddr,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire [CHIP_EVENTS-1:0] chip_event,
  input wire [LINKS*LANE_TYPES-1:0] lane_event,
  input wire [LINKS*LINK_TYPES-1:0] link_event,
  input wire single_event,
  input wire irq_n_o,
  input wire irq_n_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int NE = CHIP_EVENTS + LINKS * LANE_TYPES + LINKS * LINK_TYPES + 1;
  wire [NE-1:0] all_ev = {chip_event, lane_event, link_event, single_event};
  logic [NE-1:0] prev_ff;
  always @(posedge clk) prev_ff <= all_ev;
  wire rise_any = |(all_ev & ~prev_ff);
  wire wr_commit = psel & penable & pready & pwrite;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  od_data_a: assert property (irq_n_o == 1'b0) else $error("pin driven high");
  oe_rise_cause_a: assert property ($rose(irq_n_oe) |-> $past(rise_any, 2))
    else $error("request without event edge");
  oe_fall_cause_a: assert property ($fell(irq_n_oe) |-> $past(wr_commit, 2) ||
    $past(wr_commit, 3)) else $error("request released without write");
  wait_state_a: assert property (psel && penable && !pready |=> pready)
    else $error("no answer after one wait");
  ready_pulse_a: assert property (pready |=> !pready) else $error("ready too long");
  err_qual_a: assert property (pslverr |-> pready) else $error("error without ready");
  unmapped_err_a: assert property (pready && paddr[13:2] == 12'h100 |-> pslverr)
    else $error("unmapped not refused");
  ready_req_a: assert property (pready |-> psel && penable) else $error("stray ready");
  write_rdata_a: assert property (pready && pwrite |-> prdata == 32'h0)
    else $error("write returned data");
endmodule // irq_monitor
bind event_interrupt_aggregator irq_monitor #(.CHIP_EVENTS(CHIP_EVENTS), .LINKS(LINKS),
  .LANE_TYPES(LANE_TYPES), .LINK_TYPES(LINK_TYPES)) u_mon (.clk(clk), .rst(rst),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .chip_event(chip_event), .lane_event(lane_event),
  .link_event(link_event), .single_event(single_event), .irq_n_o(irq_n_o),
  .irq_n_oe(irq_n_oe));

// file: testbench.sv
// Self-checking bench of the event interrupt aggregator.
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, single_event = 0;
  logic [13:0] paddr = 14'h0;
  logic [31:0] pwdata = 32'h0, q;
  logic [31:0] chip_event = 32'h0;
  logic [23:0] lane_event = 24'h0;
  logic [15:0] link_event = 16'h0;
  wire [31:0] prdata;
  wire pready, pslverr, irq_n_o, irq_n_oe, irq_level, irq_pin;
  logic last_err;
  int n_errors = 0, samples_checked = 0;
  always #12.5 clk = ~clk;
  event_interrupt_aggregator u_dut (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .chip_event(chip_event), .lane_event(lane_event),
    .link_event(link_event), .single_event(single_event), .irq_n_o(irq_n_o),
    .irq_n_oe(irq_n_oe), .irq_level(irq_level));
  irq_host_line u_host (.irq_n_o(irq_n_o), .irq_n_oe(irq_n_oe), .irq_pin(irq_pin));
  // --------------------------------------------------------------------------
  // Bus and comparison tasks
  // --------------------------------------------------------------------------
  task automatic conclude();
    if (n_errors == 0 && samples_checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic xfer(input logic w, input logic [11:0] idx, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= {idx, 2'b00}; pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      n_errors++;
      conclude();
    end
    q = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] idx, input logic [31:0] exp);
    xfer(1'b0, idx, 32'h0);
    check(q, exp);
  endtask
  task automatic pin(input logic exp);
    repeat (3) @(posedge clk);
    check({31'h0, irq_pin}, {31'h0, exp});
  endtask
  // --------------------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------------------
  task automatic reset_values();
    rd(12'h01f, 32'h0);
    rd(12'h47b, 32'h08);
    rd(12'h100, 32'h0);
    check({31'h0, last_err}, 32'h1);
  endtask
  task automatic chip_block();
    xfer(1'b1, 12'h020, 32'h0f);
    rd(12'h020, 32'h0f);
    chip_event[9] <= 1'b1;
    pin(1'b0);
    chip_event[9] <= 1'b0;
    rd(12'h024, 32'h02);
    xfer(1'b1, 12'h024, 32'h02);
    rd(12'h024, 32'h0);
    pin(1'b1);
    xfer(1'b1, 12'h020, 32'h0);
    chip_event[8] <= 1'b1;
    rd(12'h024, 32'h01);
    pin(1'b1);
    chip_event[8] <= 1'b0;
  endtask
  task automatic link_block();
    xfer(1'b1, 12'h47a, 32'h01);
    lane_event[0] <= 1'b1;
    pin(1'b0);
    rd(12'h47a, 32'h01);
    xfer(1'b1, 12'h46d, 32'h01);
    rd(12'h47a, 32'h0);
    link_event[1] <= 1'b1;
    rd(12'h47a, 32'h01);
    xfer(1'b1, 12'h470, 32'h02);
    rd(12'h47a, 32'h0);
    lane_event[1] <= 1'b1;
    rd(12'h47a, 32'h0);
    pin(1'b1);
  endtask
  task automatic single_block();
    single_event <= 1'b1;
    rd(12'h47b, 32'h18);
    xfer(1'b1, 12'h47b, 32'h18);
    rd(12'h47b, 32'h08);
  endtask
  task automatic summary_irq();
    rd(12'h480, 32'h07);
    check({31'h0, irq_level}, 32'h0);
    xfer(1'b1, 12'h482, 32'h07);
    rd(12'h482, 32'h07);
    check({31'h0, irq_level}, 32'h1);
    xfer(1'b1, 12'h481, 32'h07);
    rd(12'h480, 32'h0);
    check({31'h0, irq_level}, 32'h0);
  endtask
  task automatic host_service();
    xfer(1'b1, 12'h020, 32'h04);
    chip_event[10] <= 1'b1;
    pin(1'b0);
    rd(12'h024, 32'h04);
    xfer(1'b1, 12'h020, 32'h0);
    rd(12'h024, 32'h04);
    chip_event[10] <= 1'b0;
    rd(12'h024, 32'h0);
    xfer(1'b1, 12'h024, 32'h04);
    xfer(1'b1, 12'h020, 32'h04);
    rd(12'h024, 32'h0);
    pin(1'b1);
  endtask
  task automatic last_clear_regs();
    xfer(1'b1, 12'h47a, 32'h80);
    lane_event[23] <= 1'b1;
    link_event[15] <= 1'b1;
    rd(12'h47a, 32'h80);
    xfer(1'b1, 12'h46f, 32'h80);
    rd(12'h47a, 32'h80);
    xfer(1'b1, 12'h473, 32'h08);
    rd(12'h47a, 32'h0);
    pin(1'b1);
  endtask
  task automatic reset_mid();
    single_event <= 1'b0;
    rd(12'h47b, 32'h08);
    single_event <= 1'b1;
    pin(1'b0);
    chip_event[0] <= 1'b1;
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    rd(12'h47b, 32'h08);
    rd(12'h023, 32'h01);
    rd(12'h01f, 32'h0);
    pin(1'b1);
  endtask
  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    reset_values();
    chip_block();
    host_service();
    link_block();
    last_clear_regs();
    single_block();
    summary_irq();
    reset_mid();
    conclude();
  end
endmodule // testbench
